// file: hdl/fpbh_defs.svh
// Timing counts and field positions for the flash bus host controller
`ifndef FPBH_DEFS_SVH
`define FPBH_DEFS_SVH

// Clock period in ns (20 MHz)
`define FPBH_CLK_NS          50
// Minimum reset pulse, ns, and its cycle count (rounded up)
`define FPBH_RST_PULSE_NS    500
`define FPBH_RST_PULSE_CYC   ((`FPBH_RST_PULSE_NS + `FPBH_CLK_NS - 1) / `FPBH_CLK_NS)
// Recovery after reset release, ns, and cycle count (rounded up)
`define FPBH_RST_RECOV_NS    50
`define FPBH_RST_RECOV_CYC   ((`FPBH_RST_RECOV_NS + `FPBH_CLK_NS - 1) / `FPBH_CLK_NS)
// Strobe low width, ns, and cycle count; well above the 5 ns glitch limit
`define FPBH_STROBE_NS       100
`define FPBH_STROBE_CYC      ((`FPBH_STROBE_NS + `FPBH_CLK_NS - 1) / `FPBH_CLK_NS)
// Address setup before strobe, ns, and cycle count
`define FPBH_SETUP_NS        50
`define FPBH_SETUP_CYC       ((`FPBH_SETUP_NS + `FPBH_CLK_NS - 1) / `FPBH_CLK_NS)
// Bus and counter widths
`define FPBH_ADDR_W          17
`define FPBH_DATA_W          16
`define FPBH_CNT_W           8
// Signature address line (second highest used for selection)
`define FPBH_SIG_BIT         9

`endif

// file: hdl/fpbh_pkg.sv
// Types for the flash bus host controller
package fpbh_pkg;
   typedef enum logic [2:0] {
      FPBH_IDLE,
      FPBH_RST_LOW,
      FPBH_RST_WAIT,
      FPBH_SETUP,
      FPBH_STROBE,
      FPBH_HOLD
   } fpbh_state_t;
endpackage : fpbh_pkg

// file: hdl/fpbh_host.sv
// Host controller driving a parallel boot-block flash bus
`timescale 1ns/1ns
`default_nettype none
`include "fpbh_defs.svh"

module fpbh_host (
   // Clock and reset
   input  wire logic                      mclk_i,
   input  wire logic                      srst_i,
   // User request side
   input  wire logic                      req_i,
   input  wire logic                      req_write_i,
   input  wire logic                      req_reset_i,
   input  wire logic                      req_unprotect_i,
   input  wire logic                      req_sig_i,
   input  wire logic                      byte_mode_i,
   input  wire logic [`FPBH_ADDR_W-1:0]   req_addr_i,
   input  wire logic                      req_hi_byte_i,
   input  wire logic [`FPBH_DATA_W-1:0]   req_wdata_i,
   output logic                           busy_o,
   output logic                           done_o,
   output logic [`FPBH_DATA_W-1:0]        rdata_o,
   output logic                           dev_ready_o,
   // Flash pins
   output logic                           chip_en_n_o,
   output logic                           out_en_n_o,
   output logic                           wr_en_n_o,
   output logic                           hw_reset_unprotect_n_o,
   output logic                           unprotect_hv_o,
   output logic                           sig_hv_o,
   output logic                           org_word_o,
   output logic [`FPBH_ADDR_W-1:0]        addr_lines_o,
   output logic [`FPBH_DATA_W-1:0]        dq_o,
   output logic [`FPBH_DATA_W-1:0]        dq_oe_o,
   input  wire logic [`FPBH_DATA_W-1:0]   dq_i,
   input  wire logic                      ready_busy_od_i
);

   fpbh_pkg::fpbh_state_t state_reg, state_next;
   logic [`FPBH_CNT_W-1:0]  cnt_reg, cnt_next;
   logic                    wr_reg, wr_next;
   logic                    ce_reg, ce_next, oe_reg, oe_next;
   logic                    we_reg, we_next, rp_reg, rp_next;
   logic                    uhv_reg, uhv_next, shv_reg, shv_next;
   logic                    org_reg, org_next;
   logic                    busy_reg, busy_next, done_reg, done_next;
   logic [`FPBH_ADDR_W-1:0] addr_reg, addr_next;
   logic [`FPBH_DATA_W-1:0] dout_reg, dout_next;
   logic [`FPBH_DATA_W-1:0] doe_reg, doe_next;
   logic [`FPBH_DATA_W-1:0] rd_reg, rd_next;
   logic                    rdy_reg, rdy_next;
   logic                    drive_all;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      wr_next    = wr_reg;
      ce_next    = ce_reg;
      oe_next    = oe_reg;
      we_next    = we_reg;
      rp_next    = rp_reg;
      uhv_next   = uhv_reg;
      shv_next   = shv_reg;
      org_next   = org_reg;
      busy_next  = busy_reg;
      done_next  = 1'b0;
      addr_next  = addr_reg;
      dout_next  = dout_reg;
      doe_next   = doe_reg;
      rd_next    = rd_reg;
      rdy_next   = ready_busy_od_i;
      drive_all  = 1'b0;
      unique case (state_reg)
         fpbh_pkg::FPBH_IDLE: begin
            // Access allowed only when device has released ready/busy
            if (req_i && req_reset_i) begin
               rp_next    = 1'b0;
               uhv_next   = 1'b0;
               ce_next    = 1'b1;
               busy_next  = 1'b1;
               cnt_next   = `FPBH_CNT_W'(`FPBH_RST_PULSE_CYC);
               state_next = fpbh_pkg::FPBH_RST_LOW;
            end else if (req_i && ready_busy_od_i) begin
               wr_next   = req_write_i;
               org_next  = byte_mode_i ? 1'b0 : 1'b1;
               uhv_next  = req_unprotect_i;
               shv_next  = req_sig_i && !req_write_i;
               addr_next = req_addr_i;
               // Byte mode: top data pin carries the byte select
               drive_all = !byte_mode_i;
               dout_next = {req_hi_byte_i, req_wdata_i[14:0]};
               if (drive_all)
                  dout_next = req_wdata_i;
               if (req_write_i) begin
                  // Upper seven lines floated in byte mode
                  doe_next = byte_mode_i ? 16'h80FF : 16'hFFFF;
               end else begin
                  doe_next = byte_mode_i ? 16'h8000 : 16'h0000;
               end
               busy_next  = 1'b1;
               ce_next    = 1'b0;
               cnt_next   = `FPBH_CNT_W'(`FPBH_SETUP_CYC);
               state_next = fpbh_pkg::FPBH_SETUP;
            end
         end
         fpbh_pkg::FPBH_RST_LOW: begin
            cnt_next = cnt_reg - `FPBH_CNT_W'(1);
            if (cnt_reg == `FPBH_CNT_W'(1)) begin
               rp_next    = 1'b1;
               uhv_next   = req_unprotect_i;
               cnt_next   = `FPBH_CNT_W'(`FPBH_RST_RECOV_CYC);
               state_next = fpbh_pkg::FPBH_RST_WAIT;
            end
         end
         fpbh_pkg::FPBH_RST_WAIT: begin
            // Wait both the recovery time and the ready/busy release
            if (cnt_reg != `FPBH_CNT_W'(0))
               cnt_next = cnt_reg - `FPBH_CNT_W'(1);
            else if (ready_busy_od_i) begin
               busy_next  = 1'b0;
               done_next  = 1'b1;
               state_next = fpbh_pkg::FPBH_IDLE;
            end
         end
         fpbh_pkg::FPBH_SETUP: begin
            cnt_next = cnt_reg - `FPBH_CNT_W'(1);
            if (cnt_reg == `FPBH_CNT_W'(1)) begin
               // Write keeps output enable high; never both strobes low
               oe_next    = wr_reg;
               we_next    = !wr_reg;
               cnt_next   = `FPBH_CNT_W'(`FPBH_STROBE_CYC);
               state_next = fpbh_pkg::FPBH_STROBE;
            end
         end
         fpbh_pkg::FPBH_STROBE: begin
            // Strobe width far above the glitch filter of the device
            cnt_next = cnt_reg - `FPBH_CNT_W'(1);
            if (cnt_reg == `FPBH_CNT_W'(1)) begin
               if (!wr_reg)
                  rd_next = org_reg ? dq_i : {8'h00, dq_i[7:0]};
               we_next    = 1'b1;
               oe_next    = 1'b1;
               state_next = fpbh_pkg::FPBH_HOLD;
            end
         end
         fpbh_pkg::FPBH_HOLD: begin
            // Data held one cycle past write enable rise, then released
            ce_next    = 1'b1;
            doe_next   = 16'h0000;
            shv_next   = 1'b0;
            busy_next  = 1'b0;
            done_next  = 1'b1;
            state_next = fpbh_pkg::FPBH_IDLE;
         end
         default: state_next = fpbh_pkg::FPBH_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state_reg <= fpbh_pkg::FPBH_IDLE;
         cnt_reg   <= '0;
         wr_reg    <= 1'b0;
         ce_reg    <= 1'b1;
         oe_reg    <= 1'b1;
         we_reg    <= 1'b1;
         rp_reg    <= 1'b1;
         uhv_reg   <= 1'b0;
         shv_reg   <= 1'b0;
         org_reg   <= 1'b1;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
         addr_reg  <= '0;
         dout_reg  <= '0;
         doe_reg   <= '0;
         rd_reg    <= '0;
         rdy_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         wr_reg    <= wr_next;
         ce_reg    <= ce_next;
         oe_reg    <= oe_next;
         we_reg    <= we_next;
         rp_reg    <= rp_next;
         uhv_reg   <= uhv_next;
         shv_reg   <= shv_next;
         org_reg   <= org_next;
         busy_reg  <= busy_next;
         done_reg  <= done_next;
         addr_reg  <= addr_next;
         dout_reg  <= dout_next;
         doe_reg   <= doe_next;
         rd_reg    <= rd_next;
         rdy_reg   <= rdy_next;
      end
   end

   assign busy_o                 = busy_reg;
   assign done_o                 = done_reg;
   assign rdata_o                = rd_reg;
   assign dev_ready_o            = rdy_reg;
   assign chip_en_n_o            = ce_reg;
   assign out_en_n_o             = oe_reg;
   assign wr_en_n_o              = we_reg;
   assign hw_reset_unprotect_n_o = rp_reg;
   assign unprotect_hv_o         = uhv_reg;
   assign sig_hv_o               = shv_reg;
   assign org_word_o             = org_reg;
   assign addr_lines_o           = addr_reg;
   assign dq_o                   = dout_reg;
   assign dq_oe_o                = doe_reg;

   // Helper: cycles reset has been low
   logic [`FPBH_CNT_W-1:0] rlow_cnt;
   always_ff @(posedge mclk_i) begin
      if (srst_i || rp_reg)
         rlow_cnt <= '0;
      else
         rlow_cnt <= rlow_cnt + `FPBH_CNT_W'(1);
   end

   no_write_oe_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !we_reg |-> oe_reg) else $error("Output enable low in write");
   no_all_low_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !(!ce_reg && !oe_reg && !we_reg)) else $error("Invalid cycle");
   reset_width_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $rose(rp_reg) |-> rlow_cnt >= `FPBH_CNT_W'(`FPBH_RST_PULSE_CYC))
      else $error("Reset pulse too short");
   read_strobe_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $fell(oe_reg) |-> !ce_reg && we_reg && !doe_reg[0])
      else $error("Bad read strobe");
   ready_wait_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $fell(ce_reg) |-> $past(ready_busy_od_i))
      else $error("Access while busy");
   write_pulse_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $fell(we_reg) |-> !we_reg [*2] ##1 we_reg)
      else $error("Write pulse width wrong");
   ce_while_reset_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !rp_reg |-> ce_reg) else $error("Chip enabled in reset");
   byte_upper_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      !org_reg |-> doe_reg[14:8] == 7'h00)
      else $error("Upper lines driven in byte mode");
   data_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
      $rose(we_reg) |-> doe_reg[0]) else $error("Data not held");

   read_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i)
      $fell(oe_reg));
   write_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i)
      $fell(we_reg));
   reset_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i)
      $rose(rp_reg));
   byte_cov_c: cover property (@(posedge mclk_i) disable iff (srst_i)
      !org_reg && !we_reg);

endmodule : fpbh_host
`default_nettype wire

// file: bench/fpbh_flash_model.sv
// Pin-level model of the boot-block flash behind the host controller
`timescale 1ns/1ns
`default_nettype none
module fpbh_flash_model #(
   parameter logic [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h00c3, // Arbitrary value
   parameter int          PROG_CYC = 6
) (
   // Clock for busy timing only
   input  wire logic        clk_i,
   // Supply above the lockout level
   input  wire logic        supply_ok_i,
   // Bus pins
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        rp_n_i,
   input  wire logic        sig_hv_i,
   input  wire logic        org_word_i,
   input  wire logic [16:0] addr_i,
   input  wire logic [15:0] dq_i,
   output logic      [15:0] dq_o,
   output logic      [15:0] dq_oe_o,
   output logic             rb_low_o
);
   logic [15:0] mem [0:255];
   logic [8:0]  alat;
   logic        wr_tog = 1'b0;
   logic        seen_tog = 1'b0;
   int          cnt = 0;
   wire         strobe_n = ce_n_i | we_n_i;
   wire  [15:0] w = sig_hv_i ? (addr_i[0] ? DEV_CODE : MFR_CODE) :
                    mem[addr_i[7:0]];
   wire         rd = !ce_n_i && !oe_n_i && we_n_i && rp_n_i;

   initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
   // Top pin is the byte select when in byte mode
   always @(negedge strobe_n)
      if (oe_n_i) alat <= {addr_i[7:0], dq_i[15]};
   // Below lockout a write never reaches the array
   always @(posedge strobe_n)
      if (oe_n_i && rp_n_i && supply_ok_i) begin
      if (org_word_i) mem[alat[8:1]] = dq_i;
      else if (alat[0]) mem[alat[8:1]][15:8] = dq_i[7:0];
      else mem[alat[8:1]][7:0] = dq_i[7:0];
      wr_tog = ~wr_tog;
   end
   always @(posedge clk_i) begin
      if (!rp_n_i) cnt <= 2;
      else if (!supply_ok_i) cnt <= 0;
      else if (wr_tog != seen_tog) cnt <= PROG_CYC;
      else if (cnt != 0) cnt <= cnt - 1;
      seen_tog <= wr_tog;
   end
   // Toggle term makes busy visible before the next clock edge
   assign rb_low_o = !rp_n_i || cnt != 0 || wr_tog != seen_tog;
   assign dq_oe_o = !rd ? 16'h0000 : org_word_i ? 16'hffff : 16'h00ff;
   // Reads are served however long the bus sat idle
   assign dq_o = org_word_i ? w :
                 {8'h00, dq_i[15] ? w[15:8] : w[7:0]};
endmodule : fpbh_flash_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the flash bus host controller
`timescale 1ns/1ns
`default_nettype none
`include "fpbh_defs.svh"
module testbench;
   logic mclk_i = 0, srst_i = 1, req_i = 0, req_write_i = 0, req_reset_i = 0;
   logic req_unprotect_i = 0, req_sig_i = 0, byte_mode_i = 0, req_hi_byte_i = 0;
   logic [16:0] req_addr_i = '0;
   logic [15:0] req_wdata_i = '0, flt = '0, sb [0:255];
   wire logic busy_o, done_o, dev_ready_o, chip_en_n_o, out_en_n_o, wr_en_n_o;
   wire logic hw_reset_unprotect_n_o, unprotect_hv_o, sig_hv_o, org_word_o;
   wire logic rb_low;
   wire logic [16:0] addr_lines_o;
   wire logic [15:0] rdata_o, dq_o, dq_oe_o, m_dq, m_oe, bus;
   wire logic ready_busy_od_i = !rb_low;
   int err_total = 0, checks = 0, seed = 32'hc44a, rp_low = 0, since_rp = 99;
   int we_low = 0;
   logic ce_q = 1, supply_ok = 1, rdy_s = 0;

   always #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) flt <= flt + 16'h1357;
   // Pin level one clock late, idle low in reset like the host flag
   always @(posedge mclk_i) rdy_s <= srst_i ? 1'b0 : ready_busy_od_i;
   // Released lines show a moving pattern, never the last value
   assign bus = (m_oe & m_dq) | (~m_oe & dq_oe_o & dq_o) | (~m_oe & ~dq_oe_o & flt);

   fpbh_host i_fpbh_host (.mclk_i, .srst_i, .req_i, .req_write_i, .req_reset_i,
      .req_unprotect_i, .req_sig_i, .byte_mode_i, .req_addr_i, .req_hi_byte_i,
      .req_wdata_i, .busy_o, .done_o, .rdata_o, .dev_ready_o, .chip_en_n_o,
      .out_en_n_o, .wr_en_n_o, .hw_reset_unprotect_n_o, .unprotect_hv_o,
      .sig_hv_o, .org_word_o, .addr_lines_o, .dq_o, .dq_oe_o, .dq_i(bus),
      .ready_busy_od_i);
   fpbh_flash_model i_fpbh_flash_model (.clk_i(mclk_i), .ce_n_i(chip_en_n_o),
      .oe_n_i(out_en_n_o), .we_n_i(wr_en_n_o), .rp_n_i(hw_reset_unprotect_n_o),
      .sig_hv_i(sig_hv_o), .org_word_i(org_word_o), .addr_i(addr_lines_o),
      .dq_i(bus), .dq_o(m_dq), .dq_oe_o(m_oe), .rb_low_o(rb_low),
      .supply_ok_i(supply_ok));

   task automatic chk(input string name, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic stop_test();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   function automatic logic [15:0] exp_rd(input logic bm, hi,
                                          input logic [15:0] w);
      return bm ? {8'h00, hi ? w[15:8] : w[7:0]} : w;
   endfunction : exp_rd

   task automatic op(input logic wr, rst, sg, bm, hi,
                     input logic [16:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      req_i <= 1; req_write_i <= wr; req_reset_i <= rst; req_sig_i <= sg;
      byte_mode_i <= bm; req_hi_byte_i <= hi; req_addr_i <= a;
      req_wdata_i <= d; req_unprotect_i <= 1'($random(seed));
      do begin @(posedge mclk_i); #1 n++; end while (busy_o !== 1'b1 && n < 200);
      @(posedge mclk_i) req_i <= 0;
      do begin @(posedge mclk_i); #1 n++; end while (done_o !== 1'b1 && n < 400);
      chk("done", done_o, 16'h0001);
   endtask : op

   // Pin monitor, sampled on the falling edge where all is settled
   always @(negedge mclk_i) if (!srst_i) begin
      if (hw_reset_unprotect_n_o === 1'b0) begin
         rp_low++;
         since_rp = 0;
         chk("uhv_in_rst", unprotect_hv_o, 0);
      end else begin
         if (rp_low > 0) chk("rst_pulse", rp_low >= `FPBH_RST_PULSE_CYC, 1);
         rp_low = 0;
         since_rp++;
      end
      if (chip_en_n_o === 1'b0 && ce_q === 1'b1) begin
         chk("ready_at_ce", ready_busy_od_i, 1);
         chk("recov_at_ce", since_rp > `FPBH_RST_RECOV_CYC, 1);
         chk("org", org_word_o, !byte_mode_i);
         chk("unprot", unprotect_hv_o, req_unprotect_i);
      end
      chk("dev_ready", dev_ready_o, rdy_s);
      if (wr_en_n_o === 1'b0) we_low++;
      else begin
         if (we_low > 0) chk("we_width", we_low >= `FPBH_STROBE_CYC, 1);
         we_low = 0;
      end
      if (out_en_n_o === 1'b0) chk("rd_pins", {chip_en_n_o, wr_en_n_o}, 2'b01);
      if (wr_en_n_o === 1'b0) chk("oe_in_wr", out_en_n_o, 1);
      if (m_oe !== 16'h0) chk("contend", dq_oe_o & m_oe, 0);
      ce_q = chip_en_n_o;
   end

   initial begin
      #2000000;
      err_total++;
      stop_test();
   end

   initial begin
      logic wr, bm, hi;
      logic [16:0] a;
      logic [15:0] d;
      logic [7:0] i;
      for (int k = 0; k < 256; k++) sb[k] = 16'hffff;
      repeat (3) @(posedge mclk_i);
      srst_i <= 0;
      op(0, 1, 0, 0, 0, 0, 0);
      op(1, 0, 0, 1, 0, 17'h5, 16'h003c);
      op(1, 0, 0, 1, 1, 17'h5, 16'h00c3);
      op(0, 0, 0, 0, 0, 17'h5, 0);
      chk("bytes_word", rdata_o, 16'hc33c);
      sb[5] = 16'hc33c;
      // Reset straight after a program, while the device is busy
      op(1, 0, 0, 0, 0, 17'h9, 16'h1234);
      op(0, 1, 0, 0, 0, 0, 0);
      sb[9] = 16'h1234;
      op(0, 0, 1, 0, 0, 17'h0, 0);
      chk("mfr", rdata_o, i_fpbh_flash_model.MFR_CODE);
      op(0, 0, 1, 0, 0, 17'h1, 0);
      chk("dev", rdata_o, i_fpbh_flash_model.DEV_CODE);
      // Writes under supply lockout must leave the array alone
      supply_ok <= 1'b0;
      op(1, 0, 0, 0, 0, 17'h9, 16'h0f0f);
      supply_ok <= 1'b1;
      op(0, 0, 0, 0, 0, 17'h9, 0);
      chk("lockout", rdata_o, sb[9]);
      // Mid-run reset puts every pin back to idle
      @(posedge mclk_i) srst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 chk("rst_en", {chip_en_n_o, out_en_n_o, wr_en_n_o}, 3'h7);
      chk("rst_busy", {busy_o, done_o, dev_ready_o}, 3'h0);
      chk("rst_pin", {hw_reset_unprotect_n_o, unprotect_hv_o}, 2'h2);
      chk("rst_dq", dq_oe_o, 16'h0000);
      chk("rst_org", org_word_o, 1);
      srst_i <= 1'b0;
      for (int k = 0; k < 80; k++) begin
         wr = 1'($random(seed));
         bm = 1'($random(seed));
         hi = 1'($random(seed));
         a = 17'($random(seed));
         d = 16'($random(seed));
         op(wr, 0, 0, bm, hi, a, d);
         i = a[7:0];
         if (wr && !bm) sb[i] = d;
         else if (wr && hi) sb[i][15:8] = d[7:0];
         else if (wr) sb[i][7:0] = d[7:0];
         else chk("rdata", rdata_o, exp_rd(bm, hi, sb[i]));
      end
      stop_test();
   end
endmodule : testbench
`default_nettype wire
